// file: multi_timer_ctl_consts.vh
// constants for the multi timer unit pin, irq and prescale control block
`ifndef MULTI_TIMER_CTL_CONSTS_VH
`define MULTI_TIMER_CTL_CONSTS_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_PIN_CONTROL_LOW  8'h02
`define IDX_PIN_CONTROL_HIGH 8'h04
`define IDX_IRQ_ENABLE       8'h06
`define IDX_IRQ_PENDING      8'h08
`define IDX_PRESCALE_PAIR_A  8'h0A

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_PIN_CONTROL      16'h0000
`define RST_IRQ_ENABLE       16'h0000
`define RST_IRQ_PENDING      16'h0000
`define RST_PRESCALE         16'h0000

// ----------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------
`define PIN_FIELD_W          4
`define EDGE_LSB             0
`define POL_BIT              3
`define PRESCALE_ONE_LSB     0
`define PRESCALE_TWO_LSB     8
`define IRQ_GROUP_W          4

// ----------------------------------------------------------------------
// subsystem operating mode codes
// ----------------------------------------------------------------------
`define OP_LOW_POWER         2'b00
`define OP_PWM_DUAL8         2'b01
`define OP_PWM_16            2'b10
`define OP_CAPTURE           2'b11

// ----------------------------------------------------------------------
// axi response codes
// ----------------------------------------------------------------------
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// file: multi_timer_ctl.v
// pin, interrupt and prescale control of the four-subsystem timer unit
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`include "multi_timer_ctl_consts.vh"

// Operation
// - edge field picks capture edge and optional counter reset edge per pin
// - edge field ignored while the subsystem runs either pwm mode
// - polarity zero: output high on count 00h to 01h, low on duty match
// - polarity one: output low on count 00h to 01h, high on duty match
// - stopped pwm counter holds its pin at the polarity bit level
// - polarity bit has no effect in capture mode
// - low pin control word: four pins, edge bits 2:0 and polarity bit 3
// - high pin control word: same layout for pins five to eight
// - sixteen enable bits gate matching pending flags onto requests
// - enable bits change only by software writes
// - pending flags set by events regardless of their enable bit
// - pending flags set by hardware, write one clears, zero keeps
// - four flags per subsystem, a in lowest bit of each nibble
// - pending, pin control, enable and prescale registers reset to zero
// - prescaler ticks counter when count equals compare, ratio value plus one
// - prescale pair holds subsystem one in 7:0, subsystem two in 15:8
// - flag a to d events come from the datapath per mode
// - pins are pwm outputs in modes 01 and 10, capture inputs in 11
// - low-power subsystem pending flags cannot be cleared by software
module multi_timer_ctl #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire [7:0]        subsystem_op_select,
  input  wire [7:0]        counter_running,
  input  wire [7:0]        count_step_one,
  input  wire [7:0]        duty_match,
  input  wire [15:0]       irq_event,
  input  wire [1:0]        prescale_run,
  output reg  [1:0]        prescale_tick,
  input  wire [7:0]        timer_pin_in,
  output reg  [7:0]        timer_pin_out,
  output wire [7:0]        timer_pin_oe,
  output reg  [7:0]        capture_strobe,
  output reg  [7:0]        counter_reset,
  output wire [3:0]        irq_request,
  output wire [15:0]       pin_control_low,
  output wire [15:0]       pin_control_high
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // map an aligned byte address to a register index, or flag it unmapped
  function [8:0] reg_index;
    input [ADDR_W-1:0] addr;
    reg   [ADDR_W-1:0] idx;
    begin
      idx = addr >> 2;
      reg_index = {1'b0, idx[7:0]};
      if (addr[1:0] != 2'b00) begin
        reg_index = 9'h1_00;
      end
    end
  endfunction

  // edge field decode: returns {capture, counter reset}
  function [1:0] edge_decode;
    input [2:0] sel;
    input       rise;
    input       fall;
    reg         cap;
    reg         rst;
    begin
      cap = 1'b0;
      rst = 1'b0;
      case (sel)
        3'b000: cap = rise;
        3'b001: cap = fall;
        3'b010: begin
          cap = rise;
          rst = rise;
        end
        3'b011: begin
          cap = fall;
          rst = fall;
        end
        3'b100: cap = rise | fall;
        3'b101: begin
          cap = rise | fall;
          rst = rise;
        end
        3'b110: begin
          cap = rise | fall;
          rst = fall;
        end
        default: begin
          cap = rise | fall;
          rst = rise | fall;
        end
      endcase
      edge_decode = {cap, rst};
    end
  endfunction

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg  [15:0] pin_ctl_low_q;
  reg  [15:0] pin_ctl_high_q;
  reg  [15:0] irq_enable_q;
  reg  [15:0] irq_pending_q;
  reg  [15:0] irq_pending_d;
  reg  [15:0] prescale_q;
  reg  [7:0]  pre_cnt_q [0:1];
  reg  [7:0]  pin_prev_q;

  reg              aw_held_q;
  reg              w_held_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg [31:0]       wdata_q;
  reg [3:0]        wstrb_q;

  // write decode works from the held address and strobes
  wire [31:0] pin_ctl_all = {pin_ctl_high_q, pin_ctl_low_q};
  wire        do_write    = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire [8:0]  wr_idx      = reg_index(awaddr_q);
  wire [8:0]  rd_idx      = reg_index(s_axi_araddr);
  // writes missing either low byte strobe are refused so that half a field never lands
  wire        full_word   = (wstrb_q[1:0] == 2'b11);

  wire wr_map = (wr_idx == {1'b0, `IDX_PIN_CONTROL_LOW})  |
                (wr_idx == {1'b0, `IDX_PIN_CONTROL_HIGH}) |
                (wr_idx == {1'b0, `IDX_IRQ_ENABLE})       |
                (wr_idx == {1'b0, `IDX_IRQ_PENDING})      |
                (wr_idx == {1'b0, `IDX_PRESCALE_PAIR_A});
  wire wr_ok  = do_write & wr_map & full_word;

  // contents exported so the datapath sees polarity and edge fields
  assign pin_control_low  = pin_ctl_low_q;
  assign pin_control_high = pin_ctl_high_q;

  // ----------------------------------------------------------------------
  // axi write channels
  // ----------------------------------------------------------------------
  // each channel stalls while its item is held or a response waits
  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;

  // address and data are latched in either order, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      awaddr_q     <= {ADDR_W{1'b0}};
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------

  // only software writes touch these; hardware never alters enables
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_ctl_low_q  <= `RST_PIN_CONTROL;
      pin_ctl_high_q <= `RST_PIN_CONTROL;
      irq_enable_q   <= `RST_IRQ_ENABLE;
      prescale_q     <= `RST_PRESCALE;
    end else if (wr_ok) begin
      case (wr_idx[7:0])
        `IDX_PIN_CONTROL_LOW:  pin_ctl_low_q  <= wdata_q[15:0];
        `IDX_PIN_CONTROL_HIGH: pin_ctl_high_q <= wdata_q[15:0];
        `IDX_IRQ_ENABLE:       irq_enable_q   <= wdata_q[15:0];
        `IDX_PRESCALE_PAIR_A:  prescale_q     <= wdata_q[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // pending flags
  // ----------------------------------------------------------------------

  // set wins over a clear in the same cycle so no event is lost
  always @* begin : pend_next
    integer s;
    reg [15:0] clr;
    clr = 16'h0000;
    s   = 0;
    if (wr_ok && wr_idx[7:0] == `IDX_IRQ_PENDING) begin
      clr = wdata_q[15:0];
    end
    for (s = 0; s < 4; s = s + 1) begin
      if (subsystem_op_select[2*s +: 2] == `OP_LOW_POWER) begin
        clr[`IRQ_GROUP_W*s +: `IRQ_GROUP_W] = 4'h0;
      end
    end
    // events arrive already mapped per mode, a..d per nibble
    irq_pending_d = (irq_pending_q & ~clr) | irq_event;
  end

  // pending register, updated every edge from the next-state logic
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_pending_q <= `RST_IRQ_PENDING;
    end else begin
      irq_pending_q <= irq_pending_d;
    end
  end

  // one request per subsystem from its enabled nibble
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : req
      assign irq_request[g] =
        |(irq_pending_q[4*g +: 4] & irq_enable_q[4*g +: 4]);
    end
  endgenerate

  // ----------------------------------------------------------------------
  // prescalers for subsystems one and two
  // ----------------------------------------------------------------------

  // count restarts on match, so compare n divides by n plus one
  always @(posedge aclk) begin : pre_blk
    integer p;
    if (!aresetn) begin
      pre_cnt_q[0]  <= 8'h00;
      pre_cnt_q[1]  <= 8'h00;
      prescale_tick <= 2'b00;
    end else begin
      for (p = 0; p < 2; p = p + 1) begin
        prescale_tick[p] <= 1'b0;
        // frozen while not running, as in low power
        if (prescale_run[p]) begin
          if (pre_cnt_q[p] == prescale_q[8*p +: 8]) begin
            pre_cnt_q[p]     <= 8'h00;
            prescale_tick[p] <= 1'b1;
          end else begin
            pre_cnt_q[p] <= pre_cnt_q[p] + 8'h01;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // timer pins: pwm drive and capture decode
  // ----------------------------------------------------------------------

  // pin i belongs to subsystem i/2; oe only in the two pwm modes
  generate
    for (g = 0; g < 8; g = g + 1) begin : oe
      assign timer_pin_oe[g] =
        (subsystem_op_select[2*(g/2) +: 2] == `OP_PWM_DUAL8) |
        (subsystem_op_select[2*(g/2) +: 2] == `OP_PWM_16);
    end
  endgenerate

  // registered pin drive and capture decode, one edge after the cause
  always @(posedge aclk) begin : pin_blk
    integer i;
    reg [1:0] md;
    reg [2:0] edg;
    reg       pol;
    reg [1:0] cr;
    if (!aresetn) begin
      timer_pin_out  <= 8'h00;
      capture_strobe <= 8'h00;
      counter_reset  <= 8'h00;
      // follow the pin in reset so a high pin gives no false edge later
      pin_prev_q     <= timer_pin_in;
    end else begin
      pin_prev_q <= timer_pin_in;
      for (i = 0; i < 8; i = i + 1) begin
        md  = subsystem_op_select[2*(i/2) +: 2];
        edg = pin_ctl_all[`PIN_FIELD_W*i + `EDGE_LSB +: 3];
        pol = pin_ctl_all[`PIN_FIELD_W*i + `POL_BIT];
        cr  = edge_decode(edg, timer_pin_in[i] & ~pin_prev_q[i],
                          ~timer_pin_in[i] & pin_prev_q[i]);
        // edge field only acts in capture mode
        if (md == `OP_CAPTURE) begin
          capture_strobe[i] <= cr[1];
          counter_reset[i]  <= cr[0];
        end else begin
          capture_strobe[i] <= 1'b0;
          counter_reset[i]  <= 1'b0;
        end
        if (!timer_pin_oe[i]) begin
          timer_pin_out[i] <= 1'b0;
        end else if (!counter_running[i]) begin
          timer_pin_out[i] <= pol;
        end else if (duty_match[i]) begin
          timer_pin_out[i] <= pol;
        end else if (count_step_one[i]) begin
          timer_pin_out[i] <= ~pol;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------------
  // a new read waits until the previous answer has been taken
  assign s_axi_arready = ~s_axi_rvalid;

  // one read at a time, answered on the same edge that takes the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      case (rd_idx)
        {1'b0, `IDX_PIN_CONTROL_LOW}:  s_axi_rdata <= {16'h0000, pin_ctl_low_q};
        {1'b0, `IDX_PIN_CONTROL_HIGH}: s_axi_rdata <= {16'h0000, pin_ctl_high_q};
        {1'b0, `IDX_IRQ_ENABLE}:       s_axi_rdata <= {16'h0000, irq_enable_q};
        {1'b0, `IDX_IRQ_PENDING}:      s_axi_rdata <= {16'h0000, irq_pending_q};
        {1'b0, `IDX_PRESCALE_PAIR_A}:  s_axi_rdata <= {16'h0000, prescale_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: pin_partner.sv
// model of the far side of the eight timer pins
// --------------------------------------------------
// pin partner
// --------------------------------------------------
module pin_partner (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] drive,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // the device wins a pin while its enable is up, else the bench level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule

// file: multi_timer_ctl_asserts.sv
// port-level checks for the timer control block
// --------------------------------------------------
// checker
// --------------------------------------------------
module multi_timer_ctl_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  subsystem_op_select,
  input wire logic [7:0]  counter_running,
  input wire logic [7:0]  count_step_one,
  input wire logic [7:0]  duty_match,
  input wire logic [7:0]  timer_pin_in,
  input wire logic [7:0]  timer_pin_out,
  input wire logic [7:0]  timer_pin_oe,
  input wire logic [7:0]  capture_strobe,
  input wire logic [7:0]  counter_reset,
  input wire logic [3:0]  irq_request,
  input wire logic [15:0] pin_control_low,
  input wire logic [15:0] pin_control_high
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic       pwm0;
  logic       cap0;
  logic [2:0] eg;
  logic       cr, cf, rr, rf;
  // pin zero belongs to subsystem zero; only its pin is watched
  assign pwm0 = subsystem_op_select[1] ^ subsystem_op_select[0];
  assign cap0 = &subsystem_op_select[1:0];
  assign eg   = pin_control_low[2:0];
  // expected capture and reset per edge code
  assign cr = eg[2] | ~eg[0];
  assign cf = eg[2] | eg[0];
  assign rr = eg == 3'h2 || eg == 3'h5 || eg == 3'h7;
  assign rf = eg == 3'h3 || eg == 3'h6 || eg == 3'h7;
  a_reset_clears:
    assert property ($rose(aresetn) |-> !pin_control_low
      && !pin_control_high && !irq_request)
    else $error("registers not clear after reset");
  a_oe_in_pwm:
    assert property (timer_pin_oe[0] == pwm0)
    else $error("pin enable does not follow mode");
  a_step_drives:
    assert property (pwm0 && counter_running[0] && count_step_one[0]
      && !duty_match[0] |=> timer_pin_out[0] != $past(pin_control_low[3]))
    else $error("pin wrong after counter step");
  a_duty_drives:
    assert property (pwm0 && counter_running[0] && duty_match[0]
      |=> timer_pin_out[0] == $past(pin_control_low[3]))
    else $error("pin wrong after duty match");
  a_stop_holds:
    assert property (pwm0 && !counter_running[0]
      |=> timer_pin_out[0] == $past(pin_control_low[3]))
    else $error("stopped pin not at polarity");
  a_no_cap_else:
    assert property (!cap0 |=> !capture_strobe[0] && !counter_reset[0])
    else $error("capture outside capture mode");
  a_cap_out_low:
    assert property (cap0 |=> !timer_pin_out[0])
    else $error("pin driven in capture mode");
  a_cap_rise:
    assert property (cap0 && $rose(timer_pin_in[0]) |=>
      capture_strobe[0] == $past(cr) && counter_reset[0] == $past(rr))
    else $error("wrong response to rising edge");
  a_cap_fall:
    assert property (cap0 && $fell(timer_pin_in[0]) |=>
      capture_strobe[0] == $past(cf) && counter_reset[0] == $past(rf))
    else $error("wrong response to falling edge");
  c_step: cover property (pwm0 && count_step_one[0]);
  c_cap: cover property (cap0 && capture_strobe[0]);
  c_irq: cover property (irq_request != 4'h0);
endmodule

bind multi_timer_ctl multi_timer_ctl_asserts u_multi_timer_ctl_asserts (
  .aclk, .aresetn, .subsystem_op_select, .counter_running,
  .count_step_one, .duty_match, .timer_pin_in, .timer_pin_out,
  .timer_pin_oe, .capture_strobe, .counter_reset, .irq_request,
  .pin_control_low, .pin_control_high);

// file: versatile_timer_pin_irq_prescale_test.sv
// self-checking bench for the timer pin, irq and prescale control
`include "multi_timer_ctl_consts.vh"
// --------------------------------------------------
// bench
// --------------------------------------------------
module versatile_timer_pin_irq_prescale_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  ad_low  = `IDX_PIN_CONTROL_LOW << 2;
  localparam logic [7:0]  ad_high = `IDX_PIN_CONTROL_HIGH << 2;
  localparam logic [7:0]  ad_en   = `IDX_IRQ_ENABLE << 2;
  localparam logic [7:0]  ad_pend = `IDX_IRQ_PENDING << 2;
  localparam logic [7:0]  ad_pre  = `IDX_PRESCALE_PAIR_A << 2;
  localparam logic [1:0]  ok      = `RESP_OKAY;
  localparam logic [1:0]  err     = `RESP_SLVERR;
  // nibble n: capture rise, capture fall, reset rise, reset fall
  localparam logic [31:0] edge_tab = 32'hFDEC_5A48;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = '0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, prescale_tick;
  wire  [31:0] s_axi_rdata;
  logic [7:0]  subsystem_op_select = '0, counter_running = '0;
  logic [7:0]  count_step_one = '0, duty_match = '0, drive = '0;
  logic [15:0] irq_event = '0;
  logic [1:0]  prescale_run = '0;
  wire  [7:0]  timer_pin_in, timer_pin_out, timer_pin_oe;
  wire  [7:0]  capture_strobe, counter_reset;
  wire  [3:0]  irq_request;
  wire  [15:0] pin_control_low, pin_control_high;
  int          failures = 0;
  int          n_checks = 0;
  // address, word written, word read back, response
  logic [41:0] rows [6] = '{
    {ad_low, 16'hA5C7, 16'hA5C7, ok}, {ad_high, 16'h5A3E, 16'h5A3E, ok},
    {ad_en, 16'hF00F, 16'hF00F, ok}, {ad_pend, 16'hFFFF, 16'h0000, ok},
    {ad_pre, 16'h0302, 16'h0302, ok}, {8'h0C, 16'h1234, 16'h0000, err}};
  logic [7:0]  adr [5] = '{ad_low, ad_high, ad_en, ad_pend, ad_pre};
  // compare word, then tick counts expected over 24 run cycles
  logic [31:0] pre [2] = '{{16'h0300, 8'h18, 8'h06},
                           {16'h0702, 8'h08, 8'h03}};
  // 250 MHz clock
  always #2 aclk = ~aclk;
  multi_timer_ctl #(.ADDR_W(8)) u_multi_timer_ctl (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .subsystem_op_select, .counter_running, .count_step_one,
    .duty_match, .irq_event, .prescale_run, .prescale_tick, .timer_pin_in,
    .timer_pin_out, .timer_pin_oe, .capture_strobe, .counter_reset,
    .irq_request, .pin_control_low, .pin_control_high);
  pin_partner u_pin_partner (.pin_out(timer_pin_out), .pin_oe(timer_pin_oe),
    .drive, .pin_in(timer_pin_in));
  // verdict and end of run
  task automatic complete_run();
    $display("mismatches %0d, checks %0d", failures, n_checks);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a wait that ran out of cycles ends the run
  task automatic limit(input int n);
    if (n >= 40) begin
      failures++;
      complete_run();
    end
  endtask
  // write with the given strobes; address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 40);
    s_axi_bready <= 1'h0;
    limit(n);
    chk(32'(s_axi_bresp), 32'(r));
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 40);
    s_axi_rready <= 1'h0;
    limit(n);
    chk(s_axi_rdata, {16'h0000, d});
    chk(32'(s_axi_rresp), 32'(r));
  endtask
  // one-cycle step and duty pulses, then settle
  task automatic pins(input logic [7:0] s, input logic [7:0] d);
    @(posedge aclk);
    count_step_one <= s;
    duty_match <= d;
    @(posedge aclk);
    count_step_one <= '0;
    duty_match <= '0;
    @(negedge aclk);
  endtask
  // main sequence
  initial begin
    logic [41:0] w;
    logic [7:0]  g;
    int          t0, t1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (rows[i]) begin
      w = rows[i];
      wr(w[41:34], w[33:18], 4'hF, w[1:0]);
      rd(w[41:34], w[17:2], w[1:0]);
    end
    chk(32'(pin_control_low), 32'h0000_A5C7);
    chk(32'(pin_control_high), 32'h0000_5A3E);
    wr(ad_low, 16'h1111, 4'h1, err);
    wr(8'h09, 16'h1111, 4'hF, err);
    rd(ad_low, 16'hA5C7, ok);
    // mid-run reset clears every register
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (adr[i]) rd(adr[i], 16'h0000, ok);
    // prescaler ratio, counted over 24 run cycles from a zero count
    foreach (pre[i]) begin
      wr(ad_pre, pre[i][31:16], 4'hF, ok);
      @(posedge aclk);
      prescale_run <= 2'h3;
      t0 = 0;
      t1 = 0;
      for (int k = 1; k <= 25; k++) begin
        @(posedge aclk);
        t0 += prescale_tick[0];
        t1 += prescale_tick[1];
        if (k == 24) prescale_run <= 2'h0;
      end
      chk(32'(t0), 32'(pre[i][15:8]));
      chk(32'(t1), 32'(pre[i][7:0]));
    end
    // pwm pins, polarity one on pins 1, 3, 4 and 6, both pwm modes
    wr(ad_low, 16'h8087, 4'hF, ok);
    wr(ad_high, 16'h0F08, 4'hF, ok);
    subsystem_op_select <= 8'h65;
    counter_running <= 8'hFF;
    pins(8'hFF, 8'h00);
    chk(32'(timer_pin_oe), 32'h0000_00FF);
    chk(32'(timer_pin_out), 32'h0000_00A5);
    pins(8'h00, 8'hFF);
    chk(32'(timer_pin_out), 32'h0000_005A);
    pins(8'hFF, 8'h00);
    @(posedge aclk);
    counter_running <= 8'h00;
    pins(8'h00, 8'h00);
    chk(32'(timer_pin_out), 32'h0000_005A);
    @(posedge aclk);
    subsystem_op_select <= 8'hFF;
    pins(8'hFF, 8'hFF);
    chk(32'(timer_pin_oe), 32'h0000_0000);
    chk(32'(timer_pin_out), 32'h0000_0000);
    // every edge code on pins 0 and 4: one rise, then one fall
    for (int c = 0; c < 8; c++) begin
      wr(ad_low, 16'(c), 4'hF, ok);
      wr(ad_high, 16'(c), 4'hF, ok);
      g = '0;
      for (int p = 0; p < 2; p++) begin
        @(posedge aclk);
        drive <= p ? 8'h00 : 8'h11;
        repeat (3) begin
          @(negedge aclk);
          g = g | ({capture_strobe[4], 1'h0, counter_reset[4], 1'h0,
                    capture_strobe[0], 1'h0, counter_reset[0], 1'h0} >> p);
        end
      end
      chk(32'(g), 32'({2{edge_tab[4*c +: 4]}}));
    end
    // events set flags with enables clear; enables gate the requests
    wr(ad_en, 16'h0000, 4'hF, ok);
    @(posedge aclk);
    irq_event <= 16'h8421;
    @(posedge aclk);
    irq_event <= '0;
    rd(ad_pend, 16'h8421, ok);
    @(negedge aclk);
    chk(32'(irq_request), 32'h0000_0000);
    wr(ad_en, 16'h8400, 4'hF, ok);
    @(negedge aclk);
    chk(32'(irq_request), 32'h0000_000C);
    wr(ad_pend, 16'h0401, 4'hF, ok);
    rd(ad_pend, 16'h8020, ok);
    @(negedge aclk);
    chk(32'(irq_request), 32'h0000_0008);
    @(posedge aclk);
    subsystem_op_select <= 8'hF3;
    wr(ad_pend, 16'hFFFF, 4'hF, ok);
    rd(ad_pend, 16'h0020, ok);
    rd(ad_en, 16'h8400, ok);
    complete_run();
  end
endmodule
